// ### timer_pkg.sv
package timer_pkg;

  // Register offsets on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LOW = 4'h1;
  localparam logic [3:0] ADDR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;

  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CNT = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_SUB_LO = 4;
  localparam int CTRL_RUNH = 6;

  // Status bits
  localparam int ST_OVF_LOW = 0;
  localparam int ST_OVF_HIGH = 1;
  localparam int ST_DONE = 2;
  localparam int ST_W = 3;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;

  // Low-power clock nominal rate and system rate
  localparam int LP_CLK_KHZ = 100;
  localparam int SYS_CLK_KHZ = 10000;
  localparam int LP_PERIOD_CYCLES = SYS_CLK_KHZ / LP_CLK_KHZ;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } mode_t;

  typedef enum logic [1:0] {
    SUB_A,
    SUB_B,
    SUB_C,
    SUB_RSV
  } sub_t;

  // Control register contents
  typedef struct packed {
    logic run_high;
    logic [1:0] sub;
    logic [1:0] mode;
    logic count_ext;
    logic run;
  } ctrl_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

// ### four_mode_timer_counter.sv
`timescale 1ns/1ps
// Overview of operation
// - Timer operation advances the count once per system-clock-derived period.
// - Counter operation advances on each falling edge of the external input.
// - Four modes 0 to 3, some with lettered sub-modes.
// - Mode 0: 8-bit counter behind a divide-by-32 prescaler, 13 bits.
// - Mode 1a: low and high bytes joined as one 16-bit counter.
// - Mode 1b: 16-bit count started by PWM trigger, single-shot measurement.
// - Mode 1c: 16-bit count started by PWM trigger for baud-rate measurement.
// - Mode 2: low byte counts, reloaded from high byte on overflow.
// - Mode 3a: low and high bytes are two independent 8-bit counters.
// - Mode 3b: low byte counts edges of the 100 kHz low-power clock.
// - Mode 3b: high byte counts time between low-power clock edges.
module four_mode_timer_counter
  import timer_pkg::*;
#(
  parameter int PRESCALE_DIV = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Count sources from outside the clock domain
  input wire logic count_in,
  input wire logic lp_clk_in,
  // Start pulse from the PWM unit, same clock
  input wire logic pwm_trigger,
  // Interrupt and measurement window busy
  output logic irq,
  output logic meas_busy
);

  bus_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  ctrl_t ctrl_q;
  logic [7:0] low_count_byte_q;
  logic [7:0] high_count_byte_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic busy_q;
  logic [4:0] pre_q;
  logic [1:0] cnt_sync_q;
  logic [1:0] lp_sync_q;
  logic cnt_prev_q;
  logic lp_prev_q;
  logic [1:0] lp_fill_q;

  // Flush length of the lp synchroniser and its edge memory
  localparam logic [1:0] LP_FILL_DONE = 2'h3;

  // Register write hit; four registers share this decode
  function automatic logic write_hit(input bus_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Byte increment with a deliberate wrap, used by both count bytes
  function automatic logic [7:0] byte_inc(input logic [7:0] b);
    return 8'(b + 8'h01);
  endfunction

  // Sticky next value: clear on read, but a new event wins
  function automatic logic [ST_W-1:0] sticky_next(input logic [ST_W-1:0] s,
    input logic clr, input logic [ST_W-1:0] set);
    return (clr ? '0 : s) | set;
  endfunction

  // Flag word widened to a read byte, upper bits zero
  function automatic logic [7:0] pad_byte(input logic [ST_W-1:0] v);
    return 8'(v);
  endfunction

  // Count pin: two flops, then an edge memory
  // Reset to the idle-high level so no false fall follows reset
  // Limitation: pulses shorter than one clock period may be lost
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_sync_q <= 2'h3;
      cnt_prev_q <= 1'b1;
    end else begin
      cnt_sync_q <= {cnt_sync_q[0], count_in};
      cnt_prev_q <= cnt_sync_q[1];
    end
  end

  // Low-power clock pin: two flops, then an edge memory
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lp_sync_q <= 2'h0;
      lp_prev_q <= 1'b0;
    end else begin
      lp_sync_q <= {lp_sync_q[0], lp_clk_in};
      lp_prev_q <= lp_sync_q[1];
    end
  end

  // The lp pin runs free and has no idle level, so its edges
  // are ignored until the flops above hold real samples
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lp_fill_q <= 2'h0;
    end else if (lp_fill_q != LP_FILL_DONE) begin
      lp_fill_q <= 2'(lp_fill_q + 2'h1);
    end
  end

  // Edge detection after synchronisation
  wire cnt_fall = cnt_prev_q & ~cnt_sync_q[1];
  wire lp_edge = (lp_fill_q == LP_FILL_DONE) && (lp_prev_q ^ lp_sync_q[1]);

  // Mode decode
  mode_t mode;
  sub_t sub;
  assign mode = mode_t'(ctrl_q.mode);
  assign sub = sub_t'(ctrl_q.sub);
  wire is_trig = (mode == MODE_16BIT) && (sub == SUB_B || sub == SUB_C);
  wire is_lp = (mode == MODE_SPLIT) && (sub == SUB_B);
  // Sub-mode code 3 is reserved and behaves as sub-mode a

  // Register write decodes
  wire wr_ctrl = write_hit(req, ADDR_CTRL);
  wire wr_low = write_hit(req, ADDR_LOW);
  wire wr_high = write_hit(req, ADDR_HIGH);
  wire wr_mask = write_hit(req, ADDR_MASK);

  // Tick source: one system clock per period, or external falling edge
  wire src_tick = ctrl_q.count_ext ? cnt_fall : 1'b1;

  // Measurement modes run only between trigger and overflow
  // Outside a window the count holds, so software sees the last result
  wire run_ok = ctrl_q.run && (!is_trig || busy_q);

  // Prescaler gates the tick in mode 0 only
  // It steps on source ticks, so counter operation also divides
  wire pre_wrap = (pre_q == 5'(PRESCALE_DIV - 1));
  wire tick_main = run_ok && src_tick &&
    ((mode != MODE_13BIT) || pre_wrap);

  // Low byte tick: lp edges in split b, main tick otherwise
  // Split b keeps its own run gate, as the lp source is not the tick
  wire low_tick = is_lp ? (ctrl_q.run && lp_edge) : tick_main;
  wire low_full = (low_count_byte_q == BYTE_MAX);
  wire high_full = (high_count_byte_q == BYTE_MAX);

  // High byte tick per mode
  logic high_tick;
  always_comb begin
    unique case (mode)
      // Mode 0 keeps its 13 bits in the low byte and the prescaler
      MODE_13BIT: begin
        high_tick = 1'b0;
      end
      // Carry out of the low byte
      MODE_16BIT: begin
        high_tick = tick_main && low_full;
      end
      // High byte only holds the reload value
      MODE_RELOAD: begin
        high_tick = 1'b0;
      end
      // Own run bit, independent of the low byte
      MODE_SPLIT: begin
        high_tick = ctrl_q.run_high && src_tick;
      end
    endcase
  end

  // Overflow events
  wire ovf_low = low_tick && low_full && (mode != MODE_16BIT);
  wire ovf_high = high_tick && high_full;
  wire meas_end = is_trig && busy_q && ovf_high;
  // Mode 1 reports its wrap on the high byte only

  // Start, restart and reload conditions
  wire trig_start = is_trig && ctrl_q.run && pwm_trigger && !busy_q;
  wire lp_restart = is_lp && ctrl_q.run && lp_edge;
  wire reload_now = (mode == MODE_RELOAD) && low_full;

  // Low byte next value; a software write has the last word
  logic [7:0] low_d;
  always_comb begin
    low_d = low_count_byte_q;
    if (low_tick) begin
      if (reload_now) begin
        // Reload instead of wrap keeps the period software-defined
        low_d = high_count_byte_q;
      end else begin
        low_d = byte_inc(low_count_byte_q);
      end
    end
    // Trigger clears the joined counter to start a measurement
    if (trig_start) begin
      low_d = BYTE_ZERO;
    end
    // Write wins over counting so software can preset a count
    if (wr_low) begin
      low_d = req.wdata;
    end
  end

  // High byte next value; same priority order as the low byte
  logic [7:0] high_d;
  always_comb begin
    high_d = high_count_byte_q;
    if (high_tick) begin
      high_d = byte_inc(high_count_byte_q);
    end
    // Split b: an lp edge restarts the interval timer
    if (lp_restart) begin
      high_d = BYTE_ZERO;
    end
    if (trig_start) begin
      high_d = BYTE_ZERO;
    end
    // Write wins over counting so software can preset a count
    if (wr_high) begin
      high_d = req.wdata;
    end
  end

  // Prescaler step and next value
  wire pre_step = (mode == MODE_13BIT) && run_ok && src_tick;
  wire [4:0] pre_next = pre_wrap ? 5'h00 : 5'(pre_q + 5'h01);

  // Prescaler: 5-bit divider, free-running only in mode 0
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pre_q <= 5'h00;
    end else if (pre_step) begin
      pre_q <= pre_next;
    end
  end

  // Low count byte
  always_ff @(posedge clock) begin
    if (!rstn) begin
      low_count_byte_q <= BYTE_ZERO;
    end else begin
      low_count_byte_q <= low_d;
    end
  end

  // High count byte
  always_ff @(posedge clock) begin
    if (!rstn) begin
      high_count_byte_q <= BYTE_ZERO;
    end else begin
      high_count_byte_q <= high_d;
    end
  end

  // Measurement window: trigger opens it, 16-bit wrap closes it
  // A trigger inside an open window is ignored, so the first one counts
  // Leaving the mode or clearing run drops the window at once
  always_ff @(posedge clock) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else if (!is_trig || !ctrl_q.run) begin
      busy_q <= 1'b0;
    end else if (pwm_trigger && !busy_q) begin
      busy_q <= 1'b1;
    end else if (meas_end) begin
      busy_q <= 1'b0;
    end
  end

  // Register decode
  // Map: ctrl, low, high, status, mask; other addresses read as zero
  wire rd_status = req.rd && req.addr == ADDR_STATUS;
  // Event bits line up with the status and mask bits
  logic [ST_W-1:0] ev;
  assign ev = {meas_end, ovf_high, ovf_low};
  logic [ST_W-1:0] status_d;
  assign status_d = sticky_next(status_q, rd_status, ev);
  wire irq_d = |(status_d & mask_q);

  // 16 bits are two byte reads with no latch: read low, then high,
  // and read again if the low byte wrapped in between
  logic [7:0] rmux;
  always_comb begin
    unique case (req.addr)
      ADDR_CTRL: rmux = 8'(ctrl_q);
      ADDR_LOW: rmux = low_count_byte_q;
      ADDR_HIGH: rmux = high_count_byte_q;
      ADDR_STATUS: rmux = pad_byte(status_q);
      ADDR_MASK: rmux = pad_byte(mask_q);
      default: rmux = BYTE_ZERO;
    endcase
  end

  // Control register; a write takes effect on the next edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q <= ctrl_t'(CTRL_RESET[6:0]);
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_t'(req.wdata[6:0]);
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= req.wdata[ST_W-1:0];
    end
  end

  // Sticky status; a new event wins over the read-clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= BYTE_ZERO;
    end else begin
      rdata_q <= req.rd ? rmux : BYTE_ZERO;
    end
  end

  // Level interrupt from the next status, so it follows the flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign meas_busy = busy_q;

endmodule // four_mode_timer_counter

// ### four_mode_timer_counter_assertions.sv
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
#(
  parameter int PRESCALE_DIV = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Trigger and outputs
  input wire logic pwm_trigger,
  input wire logic irq,
  input wire logic meas_busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == BYTE_ZERO)
    else $error("read data outside answer cycle");
  unmapped_zero_a: assert property (rd && addr > ADDR_MASK |=> rdata == BYTE_ZERO)
    else $error("unmapped read not zero");
  ctrl_back_a: assert property (
    wr && addr == ADDR_CTRL ##1 rd && addr == ADDR_CTRL |=> rdata == ($past(wdata, 2) & 8'h7F))
    else $error("mode readback wrong");
  meas_cause_a: assert property ($rose(meas_busy) |-> $past(pwm_trigger))
    else $error("window opened without trigger");
  meas_hold_a: assert property ($rose(meas_busy) |=> meas_busy [*8])
    else $error("window closed early");
  status_irq_a: assert property (
    rd && addr == ADDR_STATUS && irq && !$past(rd) |=> rdata != BYTE_ZERO)
    else $error("interrupt with empty status");
  mask_off_a: assert property (wr && addr == ADDR_MASK && wdata == BYTE_ZERO |=> ##1 !irq)
    else $error("masked interrupt still high");
  reset_quiet_a: assert property ($rose(rstn) |-> !irq && !meas_busy && rdata == BYTE_ZERO)
    else $error("outputs busy after reset");
endmodule // timer_checker

bind four_mode_timer_counter timer_checker #(.PRESCALE_DIV(PRESCALE_DIV)) i_timer_checker (
  .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pwm_trigger(pwm_trigger), .irq(irq), .meas_busy(meas_busy));

// ### pwm_count_partner.sv
`timescale 1ns/1ps
module pwm_count_partner (
  // Clock and bench requests
  input wire logic clock,
  input wire logic fire,
  input wire logic pulse,
  // Toward the timer
  output logic pwm_trigger = 1'b0,
  output logic count_in = 1'b1,
  output logic lp_clk_in = 1'b0
);
  int n = 0;
  // Oscillator runs free, so no framing of the slow clock
  always @(posedge clock) begin
    pwm_trigger <= fire;
    count_in <= !pulse;
    n <= (n == 49) ? 0 : n + 1;
    lp_clk_in <= (n == 49) ? !lp_clk_in : lp_clk_in;
  end
endmodule // pwm_count_partner

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import timer_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0, pulse = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic count_in, lp_clk_in, pwm_trigger, irq, meas_busy;
  logic [7:0] notes[$];
  int miscompares = 0, compares = 0, seed = 94;
  // 10 MHz
  always #50 clock = !clock;
  four_mode_timer_counter i_four_mode_timer_counter (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_in(count_in),
    .lp_clk_in(lp_clk_in), .pwm_trigger(pwm_trigger), .irq(irq), .meas_busy(meas_busy));
  pwm_count_partner i_pwm_count_partner (.clock(clock), .fire(fire), .pulse(pulse),
    .pwm_trigger(pwm_trigger), .count_in(count_in), .lp_clk_in(lp_clk_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One cycle per access; a read queues its expected data
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    if (!w) notes.push_back(d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  // Start and stop writes k edges apart, so k ticks land
  task automatic run(input logic [7:0] c, input logic [7:0] lo, input int k);
    bus(1'b1, ADDR_LOW, lo);
    bus(1'b1, ADDR_HIGH, 8'hF0);
    bus(1'b1, ADDR_CTRL, c);
    idle(k - 1);
    bus(1'b1, ADDR_CTRL, c & 8'hBE);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Answer stands only in the cycle after the strobe
  always @(posedge clock) begin
    rd_d <= rd;
    if (rd_d) begin
      check(rdata, notes.pop_front());
    end
  end
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    v = 8'($random(seed)) & 8'h3E;
    bus(1'b0, ADDR_CTRL, CTRL_RESET);
    bus(1'b1, 4'h9, 8'($random(seed)));
    bus(1'b0, 4'h9, BYTE_ZERO);
    bus(1'b1, ADDR_CTRL, v);
    bus(1'b0, ADDR_CTRL, v);
    bus(1'b1, ADDR_MASK, 8'h01);
    run(8'h05, 8'hFE, 4);
    idle(3);
    bus(1'b0, ADDR_LOW, 8'h02);
    bus(1'b0, ADDR_HIGH, 8'hF1);
    run(8'h09, 8'hFE, 5);
    check({7'h00, irq}, 8'h01);
    bus(1'b0, ADDR_STATUS, 8'h01);
    bus(1'b0, ADDR_STATUS, 8'h00);
    check({7'h00, irq}, 8'h00);
    bus(1'b0, ADDR_LOW, 8'hF3);
    bus(1'b1, ADDR_MASK, 8'h00);
    run(8'h01, 8'h00, 64);
    bus(1'b0, ADDR_LOW, 8'h02);
    run(8'h4D, 8'h00, 3);
    bus(1'b0, ADDR_LOW, 8'h03);
    bus(1'b0, ADDR_HIGH, 8'hF3);
    run(8'h07, 8'h00, 1);
    bus(1'b1, ADDR_CTRL, 8'h07);
    repeat (3) begin
      pulse <= 1'b1;
      idle(2);
      pulse <= 1'b0;
      idle(2);
    end
    idle(6);
    bus(1'b1, ADDR_CTRL, 8'h06);
    bus(1'b0, ADDR_LOW, 8'h03);
    foreach (v[i]) if (i < 2) begin
      bus(1'b1, ADDR_CTRL, i ? 8'h25 : 8'h15);
      fire <= 1'b1;
      idle(1);
      fire <= 1'b0;
      idle(12);
      check({7'h00, meas_busy}, 8'h01);
      bus(1'b1, ADDR_CTRL, 8'h00);
    end
    // Split b aligned to an lp edge: one edge counted, then 20 clocks
    @(lp_clk_in);
    bus(1'b1, ADDR_LOW, BYTE_ZERO);
    bus(1'b1, ADDR_CTRL, 8'h5D);
    idle(20);
    bus(1'b1, ADDR_CTRL, 8'h1C);
    bus(1'b0, ADDR_LOW, 8'h01);
    bus(1'b0, ADDR_HIGH, 8'h14);
    idle(3);
    print_verdict();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule // testbench
